// >>> rtl/remote_input_function_control.sv
// Remote contact function decoder, display filter and quick-programming gating.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module remote_input_function_control #(
   parameter int unsigned MIN_CYCLES = remote_ctl_pkg::MIN_LOW_CYCLES
) (
   input  wire logic                              i_clk,
   input  wire logic                              i_nrst,
   input  wire logic                              i_remote_input_one_n,
   input  wire logic                              i_remote_input_two_n,
   input  wire logic                              i_program_disable_pin_n,
   input  wire logic [3:0]                        i_addr,
   input  wire logic [15:0]                       i_wdata,
   input  wire logic                              i_wr,
   input  wire logic                              i_rd,
   output logic [15:0]                            o_rdata,
   input  wire logic                              i_sample_valid,
   input  wire logic [remote_ctl_pkg::TEMP_W-1:0] i_temp,
   input  wire logic                              i_panel_select_total,
   output logic [remote_ctl_pkg::TEMP_W-1:0]      o_display_temp,
   output logic                                   o_show_total,
   output logic                                   o_total_clear,
   output logic                                   o_total_enable,
   output logic                                   o_total_hold,
   output logic                                   o_alarm_clear,
   output logic                                   o_peak_mode,
   output logic                                   o_valley_mode,
   output logic [remote_ctl_pkg::TEMP_W-1:0]      o_offset,
   output logic [remote_ctl_pkg::TEMP_W-1:0]      o_peak,
   output logic [remote_ctl_pkg::TEMP_W-1:0]      o_valley,
   output logic [10:0]                            o_panel_offer
);
   import remote_ctl_pkg::*;

   function automatic logic is_fn(input logic [3:0] sel, input remote_fn_t fn);
      return sel == fn;
   endfunction

   logic [15:0]       cfg;
   logic [15:0]       panel;
   logic [TEMP_W-1:0] offset;
   logic [TEMP_W-1:0] peak;
   logic [TEMP_W-1:0] valley;
   logic [TEMP_W-1:0] held_temp;
   logic              hold;
   logic              tot_run;
   logic              show_total;
   logic              peak_track;
   logic              valley_track;
   logic              pgm_sync1_n;
   logic              pgm_sync2_n;
   logic [TEMP_W-1:0] filt_temp;
   logic              act1;
   logic              fall1;
   logic              rise1;
   logic              act2_raw;
   logic              fall2_raw;
   logic              rise2_raw;

   remote_input_qualifier #(.MIN_CYCLES(MIN_CYCLES)) u_qual_one (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_pin_n  (i_remote_input_one_n),
      .o_active (act1),
      .o_fall   (fall1),
      .o_rise   (rise1)
   );

   remote_input_qualifier #(.MIN_CYCLES(MIN_CYCLES)) u_qual_two (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_pin_n  (i_remote_input_two_n),
      .o_active (act2_raw),
      .o_fall   (fall2_raw),
      .o_rise   (rise2_raw)
   );

   moving_filter u_filter (
      .i_clk          (i_clk),
      .i_nrst         (i_nrst),
      .i_sample_valid (i_sample_valid),
      .i_sample       (i_temp),
      .i_level        (cfg[CFG_FILT_LSB +: 2]),
      .o_value        (filt_temp)
   );

   wire       opt_tot = cfg[CFG_OPT_TOT];
   wire       opt_alm = cfg[CFG_OPT_ALM];
   wire       opt_ofs = cfg[CFG_OPT_OFS];
   wire [3:0] fn1     = cfg[CFG_FUNC1_LSB +: 4];
   wire [3:0] fn2     = cfg[CFG_FUNC2_LSB +: 4];
   // Input two only exists with the totalizer option fitted.
   wire       act2    = act2_raw & opt_tot;
   wire       fall2   = fall2_raw & opt_tot;
   wire       rise2   = rise2_raw & opt_tot;

   // Both inputs decode through the same function set and act in parallel.
   wire f1_ofs  = fall1 & is_fn(fn1, FN_OFFSET);
   wire f2_ofs  = fall2 & is_fn(fn2, FN_OFFSET);
   wire do_offset   = (f1_ofs | f2_ofs) & opt_ofs;
   wire clr_tot     = (fall1 & (is_fn(fn1, FN_TOT_RESET) | is_fn(fn1, FN_TOT_GATED)))
                    | (fall2 & (is_fn(fn2, FN_TOT_RESET) | is_fn(fn2, FN_TOT_GATED)));
   wire gate1       = is_fn(fn1, FN_TOT_GATED) | is_fn(fn1, FN_TOT_ENABLE);
   wire gate2       = is_fn(fn2, FN_TOT_GATED) | is_fn(fn2, FN_TOT_ENABLE);
   wire any_gate    = gate1 | (gate2 & opt_tot);
   wire gate_on     = (gate1 & act1) | (gate2 & act2);
   wire hold_lvl    = (act1 & is_fn(fn1, FN_HOLD)) | (act2 & is_fn(fn2, FN_HOLD));
   wire pv_both     = (fall1 & is_fn(fn1, FN_PV_RESET)) | (fall2 & is_fn(fn2, FN_PV_RESET));
   wire pk_fall     = (fall1 & is_fn(fn1, FN_PEAK)) | (fall2 & is_fn(fn2, FN_PEAK));
   wire pk_rise     = (rise1 & is_fn(fn1, FN_PEAK)) | (rise2 & is_fn(fn2, FN_PEAK));
   wire va_fall     = (fall1 & is_fn(fn1, FN_VALLEY)) | (fall2 & is_fn(fn2, FN_VALLEY));
   wire va_rise     = (rise1 & is_fn(fn1, FN_VALLEY)) | (rise2 & is_fn(fn2, FN_VALLEY));
   wire alm_clr     = ((fall1 & is_fn(fn1, FN_ALM_RESET)) | (fall2 & is_fn(fn2, FN_ALM_RESET))) & opt_alm;
   // A released peak or valley input stops detection so the last value is kept.
   wire pk_idle     = (is_fn(fn1, FN_PEAK) | (is_fn(fn2, FN_PEAK) & opt_tot)) & ~peak_track;
   wire va_idle     = (is_fn(fn1, FN_VALLEY) | (is_fn(fn2, FN_VALLEY) & opt_tot)) & ~valley_track;
   wire [TEMP_W-1:0] corrected = filt_temp - offset;
   wire [TEMP_W-1:0] shown     = hold ? held_temp : corrected;
   wire pgm_locked  = ~pgm_sync2_n;

   // Quick-programming offers; edit items follow their display items.
   wire [10:0] offer;
   assign offer[PNL_ALM_SHOW]  = panel[PNL_ALM_SHOW] & opt_alm;
   assign offer[PNL_ALM_EDIT]  = panel[PNL_ALM_EDIT] & offer[PNL_ALM_SHOW];
   assign offer[PNL_HYS_SHOW]  = panel[PNL_HYS_SHOW] & opt_alm;
   assign offer[PNL_HYS_EDIT]  = panel[PNL_HYS_EDIT] & offer[PNL_HYS_SHOW];
   assign offer[PNL_PV_SHOW]   = panel[PNL_PV_SHOW] & opt_tot;
   assign offer[PNL_PV_RESET]  = panel[PNL_PV_RESET] & offer[PNL_PV_SHOW];
   assign offer[PNL_OFS_SHOW]  = panel[PNL_OFS_SHOW] & opt_ofs;
   assign offer[PNL_OFS_EDIT]  = panel[PNL_OFS_EDIT] & offer[PNL_OFS_SHOW];
   assign offer[PNL_ALM_RESET] = panel[PNL_ALM_RESET] & opt_alm;
   // Display select and total reset are offered whatever the lockout pin shows.
   assign offer[PNL_SEL_DISP]  = panel[PNL_SEL_DISP] & opt_tot;
   assign offer[PNL_TOT_RESET] = panel[PNL_TOT_RESET] & opt_tot;

   wire [15:0] status = {9'h000, pgm_locked, valley_track, peak_track, tot_run, show_total, hold, act1 | act2};
   wire [15:0] rd_mux = (i_addr == ADDR_CFG)     ? cfg :
                        (i_addr == ADDR_PANEL)   ? {5'h00, offer} :
                        (i_addr == ADDR_STATUS)  ? status :
                        (i_addr == ADDR_DISPLAY) ? 16'(shown) :
                        (i_addr == ADDR_OFFSET)  ? 16'(offset) :
                        (i_addr == ADDR_PEAK)    ? 16'(peak) :
                        (i_addr == ADDR_VALLEY)  ? 16'(valley) :
                        (i_addr == ADDR_SERIAL)  ? 16'(shown) :
                        16'h0000;
   wire wr_cfg    = i_wr & (i_addr == ADDR_CFG);
   wire wr_panel  = i_wr & (i_addr == ADDR_PANEL);
   wire wr_offset = i_wr & (i_addr == ADDR_OFFSET);

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cfg         <= CFG_RESET;
         panel       <= PANEL_RESET;
         o_rdata     <= 16'h0000;
         pgm_sync1_n <= 1'b1;
         pgm_sync2_n <= 1'b1;
      end else begin
         pgm_sync1_n <= i_program_disable_pin_n;
         pgm_sync2_n <= pgm_sync1_n;
         o_rdata     <= i_rd ? rd_mux : 16'h0000;
         if (wr_cfg) cfg <= i_wdata;
         if (wr_panel) panel <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         offset <= '0;
      end else if (do_offset) begin
         offset <= offset + shown;
      end else if (wr_offset) begin
         offset <= i_wdata[TEMP_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         hold      <= 1'b0;
         held_temp <= '0;
      end else begin
         hold <= hold_lvl;
         if (hold_lvl & ~hold) held_temp <= corrected;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         tot_run <= 1'b1;
      end else begin
         tot_run <= any_gate ? gate_on : 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         show_total <= 1'b0;
      end else if (offer[PNL_SEL_DISP]) begin
         show_total <= i_panel_select_total;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         peak         <= '0;
         valley       <= '1;
         peak_track   <= 1'b0;
         valley_track <= 1'b0;
      end else begin
         if (pk_fall) peak_track <= 1'b1;
         else if (pk_rise) peak_track <= 1'b0;
         if (va_fall) valley_track <= 1'b1;
         else if (va_rise) valley_track <= 1'b0;
         // Peak and valley keep the highest and lowest reading when not being reset or held idle after release.
         if (pv_both | pk_fall) peak <= corrected;
         else if (~pk_idle & (corrected > peak)) peak <= corrected;
         if (pv_both | va_fall) valley <= corrected;
         else if (~va_idle & (corrected < valley)) valley <= corrected;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_display_temp <= '0;
         o_show_total   <= 1'b0;
         o_total_clear  <= 1'b0;
         o_total_enable <= 1'b0;
         o_total_hold   <= 1'b0;
         o_alarm_clear  <= 1'b0;
         o_peak_mode    <= 1'b0;
         o_valley_mode  <= 1'b0;
         o_offset       <= '0;
         o_peak         <= '0;
         o_valley       <= '0;
         o_panel_offer  <= '0;
      end else begin
         o_display_temp <= shown;
         o_show_total   <= show_total;
         o_total_clear  <= clr_tot;
         o_total_enable <= tot_run;
         o_total_hold   <= hold;
         o_alarm_clear  <= alm_clr;
         o_peak_mode    <= peak_track;
         o_valley_mode  <= valley_track;
         o_offset       <= offset;
         o_peak         <= peak;
         o_valley       <= valley;
         o_panel_offer  <= offer;
      end
   end
endmodule
`default_nettype wire

// >>> include/remote_ctl_pkg.sv
// Shared constants and types for the remote input function control block.
package remote_ctl_pkg;
   localparam int unsigned CLK_HZ           = 40_000_000;
   localparam int unsigned MIN_LOW_MS       = 20;
   localparam int unsigned MIN_LOW_CYCLES   = (CLK_HZ / 1000) * MIN_LOW_MS;
   localparam int unsigned QUAL_W           = 20;
   localparam int unsigned TEMP_W           = 16;
   localparam int unsigned FILT_DEPTH       = 8;
   // Register offsets of the plain register port.
   localparam logic [3:0] ADDR_CFG         = 4'h0;
   localparam logic [3:0] ADDR_PANEL       = 4'h1;
   localparam logic [3:0] ADDR_STATUS      = 4'h2;
   localparam logic [3:0] ADDR_DISPLAY     = 4'h3;
   localparam logic [3:0] ADDR_OFFSET      = 4'h4;
   localparam logic [3:0] ADDR_PEAK        = 4'h5;
   localparam logic [3:0] ADDR_VALLEY      = 4'h6;
   localparam logic [3:0] ADDR_SERIAL      = 4'h7;
   // CFG fields: function one [3:0], function two [7:4], filter level [9:8], options [12:10].
   localparam int unsigned CFG_FUNC1_LSB   = 0;
   localparam int unsigned CFG_FUNC2_LSB   = 4;
   localparam int unsigned CFG_FILT_LSB    = 8;
   localparam int unsigned CFG_OPT_TOT     = 10;
   localparam int unsigned CFG_OPT_ALM     = 11;
   localparam int unsigned CFG_OPT_OFS     = 12;
   localparam logic [15:0] CFG_RESET       = 16'h0000;
   // PANEL fields, display bit then edit bit in [7:0], then display select, total reset and alarm reset.
   localparam int unsigned PNL_ALM_SHOW    = 0;
   localparam int unsigned PNL_ALM_EDIT    = 1;
   localparam int unsigned PNL_HYS_SHOW    = 2;
   localparam int unsigned PNL_HYS_EDIT    = 3;
   localparam int unsigned PNL_PV_SHOW     = 4;
   localparam int unsigned PNL_PV_RESET    = 5;
   localparam int unsigned PNL_OFS_SHOW    = 6;
   localparam int unsigned PNL_OFS_EDIT    = 7;
   localparam int unsigned PNL_SEL_DISP    = 8;
   localparam int unsigned PNL_TOT_RESET   = 9;
   localparam int unsigned PNL_ALM_RESET   = 10;
   localparam logic [15:0] PANEL_RESET     = 16'h0000;

   typedef enum logic [3:0] {
      FN_OFFSET     = 4'h0,
      FN_TOT_RESET  = 4'h1,
      FN_TOT_GATED  = 4'h2,
      FN_TOT_ENABLE = 4'h3,
      FN_HOLD       = 4'h4,
      FN_PV_RESET   = 4'h5,
      FN_PEAK       = 4'h6,
      FN_VALLEY     = 4'h7,
      FN_ALM_RESET  = 4'h8
   } remote_fn_t;

   typedef enum logic [1:0] {
      FILT_NONE     = 2'h0,
      FILT_NORMAL   = 2'h1,
      FILT_MORE     = 2'h2,
      FILT_MAX      = 2'h3
   } filt_level_t;
endpackage

// >>> rtl/remote_input_qualifier.sv
// Synchroniser and minimum-low-time qualifier for one remote contact input.
`timescale 1ns/1ps
`default_nettype none
module remote_input_qualifier #(
   parameter int unsigned MIN_CYCLES = remote_ctl_pkg::MIN_LOW_CYCLES
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_pin_n,
   output logic      o_active,
   output logic      o_fall,
   output logic      o_rise
);
   import remote_ctl_pkg::*;
   logic                sync1_n;
   logic                sync2_n;
   logic [QUAL_W-1:0]   low_count;
   logic                active;
   wire                 count_done = (low_count >= QUAL_W'(MIN_CYCLES - 1));

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         sync1_n   <= 1'b1;
         sync2_n   <= 1'b1;
         low_count <= '0;
         active    <= 1'b0;
      end else begin
         sync1_n <= i_pin_n;
         sync2_n <= sync1_n;
         // A low shorter than the minimum never raises the active level.
         if (sync2_n) begin
            low_count <= '0;
            active    <= 1'b0;
         end else if (!count_done) begin
            low_count <= low_count + 1'b1;
         end else begin
            active <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_active <= 1'b0;
         o_fall   <= 1'b0;
         o_rise   <= 1'b0;
      end else begin
         o_active <= active;
         o_fall   <= active & ~o_active;
         o_rise   <= ~active & o_active;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/moving_filter.sv
// Moving-window averaging filter for the displayed temperature.
`timescale 1ns/1ps
`default_nettype none
module moving_filter (
   input  wire logic                              i_clk,
   input  wire logic                              i_nrst,
   input  wire logic                              i_sample_valid,
   input  wire logic [remote_ctl_pkg::TEMP_W-1:0] i_sample,
   input  wire logic [1:0]                        i_level,
   output logic [remote_ctl_pkg::TEMP_W-1:0]      o_value
);
   import remote_ctl_pkg::*;
   logic [TEMP_W-1:0] window [FILT_DEPTH];
   logic [TEMP_W+2:0] sum2;
   logic [TEMP_W+2:0] sum4;
   logic [TEMP_W+2:0] sum8;

   // Longer windows give a steadier reading at the cost of response time.
   always_comb begin
      sum2 = '0;
      sum4 = '0;
      sum8 = '0;
      for (int k = 0; k < FILT_DEPTH; k++) begin
         if (k < 2) sum2 = sum2 + (TEMP_W+3)'(window[k]);
         if (k < 4) sum4 = sum4 + (TEMP_W+3)'(window[k]);
         sum8 = sum8 + (TEMP_W+3)'(window[k]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         for (int k = 0; k < FILT_DEPTH; k++) window[k] <= '0;
         o_value <= '0;
      end else if (i_sample_valid) begin
         window[0] <= i_sample;
         for (int k = 1; k < FILT_DEPTH; k++) window[k] <= window[k-1];
         case (filt_level_t'(i_level))
            FILT_NONE:   o_value <= i_sample;
            FILT_NORMAL: o_value <= sum2[TEMP_W:1];
            FILT_MORE:   o_value <= sum4[TEMP_W+1:2];
            FILT_MAX:    o_value <= sum8[TEMP_W+2:3];
            default:     o_value <= i_sample;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> tb/contact_model.sv
// Model of the external contacts wired to the two remote inputs.
`timescale 1ns/1ps
`default_nettype none
module contact_model (
   input  wire logic i_close,
   output wire logic o_pin_n
);
   // An open contact leaves the pull-up in charge; a closed one shorts the pin to signal common.
   assign o_pin_n = ~i_close;
endmodule
`default_nettype wire

// >>> tb/remote_ctl_sva.sv
// Assertion checker for the remote input function control block.
`timescale 1ns/1ps
`default_nettype none
module remote_ctl_sva #(
   parameter int unsigned MIN_CYCLES = remote_ctl_pkg::MIN_LOW_CYCLES
) (
   input wire logic                              i_clk,
   input wire logic                              i_nrst,
   input wire logic                              i_remote_input_one_n,
   input wire logic                              i_remote_input_two_n,
   input wire logic [3:0]                        i_addr,
   input wire logic                              i_wr,
   input wire logic                              i_panel_select_total,
   input wire logic                              o_show_total,
   input wire logic                              o_total_clear,
   input wire logic                              o_alarm_clear,
   input wire logic                              o_peak_mode,
   input wire logic                              o_valley_mode,
   input wire logic [remote_ctl_pkg::TEMP_W-1:0] o_offset,
   input wire logic [10:0]                       o_panel_offer
);
   import remote_ctl_pkg::*;
   localparam logic [QUAL_W-1:0] MIN_Q = QUAL_W'(MIN_CYCLES);
   logic [QUAL_W-1:0] low1;
   logic [QUAL_W-1:0] low2;
   logic [7:0]        age;
   wire logic         qual = (low1 == MIN_Q) || (low2 == MIN_Q);
   wire logic         ofs_wr = i_wr && (i_addr == ADDR_OFFSET);
   // Age counts cycles since a contact last met the minimum closed time, so actions can be traced to it.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         low1 <= '0;
         low2 <= '0;
         age  <= 8'hff;
      end else begin
         low1 <= i_remote_input_one_n ? '0 : ((low1 == MIN_Q) ? low1 : low1 + 1'b1);
         low2 <= i_remote_input_two_n ? '0 : ((low2 == MIN_Q) ? low2 : low2 + 1'b1);
         age  <= qual ? 8'h00 : ((age == 8'hff) ? age : age + 8'h01);
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_recent_low;
      age < 8'd16;
   endsequence
   sequence s_sel_req;
      o_panel_offer[PNL_SEL_DISP] && i_panel_select_total;
   endsequence
   a_clear_after_low: assert property (o_total_clear |-> s_recent_low)
      else $error("total clear without a qualified closure");
   a_alarm_after_low: assert property (o_alarm_clear |-> s_recent_low)
      else $error("alarm clear without a qualified closure");
   a_peak_after_low: assert property ($rose(o_peak_mode) |-> s_recent_low)
      else $error("peak mode without a qualified closure");
   a_valley_after_low: assert property ($rose(o_valley_mode) |-> s_recent_low)
      else $error("valley mode without a qualified closure");
   a_alarm_edit_gated: assert property (o_panel_offer[PNL_ALM_EDIT] |-> o_panel_offer[PNL_ALM_SHOW])
      else $error("alarm edit offered while hidden");
   a_hyst_edit_gated: assert property (o_panel_offer[PNL_HYS_EDIT] |-> o_panel_offer[PNL_HYS_SHOW])
      else $error("hysteresis edit offered while hidden");
   a_pv_reset_gated: assert property (o_panel_offer[PNL_PV_RESET] |-> o_panel_offer[PNL_PV_SHOW])
      else $error("peak valley reset offered while hidden");
   a_ofs_edit_gated: assert property (o_panel_offer[PNL_OFS_EDIT] |-> o_panel_offer[PNL_OFS_SHOW])
      else $error("offset entry offered while hidden");
   a_switch_frozen: assert property ($changed(o_show_total) |-> $past(o_panel_offer[PNL_SEL_DISP])
      || $past(o_panel_offer[PNL_SEL_DISP], 2)) else $error("display switched while switching locked");
   a_switch_follows: assert property (s_sel_req |-> ##[1:4] o_show_total)
      else $error("allowed display switch not taken");
   a_offset_source: assert property ($changed(o_offset) |-> $past(ofs_wr) || $past(ofs_wr, 2) || age < 8'd16)
      else $error("offset changed without write or capture");
endmodule
bind remote_input_function_control remote_ctl_sva #(.MIN_CYCLES(MIN_CYCLES)) u_sva (
   .i_clk, .i_nrst, .i_remote_input_one_n, .i_remote_input_two_n, .i_addr, .i_wr, .i_panel_select_total,
   .o_show_total, .o_total_clear, .o_alarm_clear, .o_peak_mode, .o_valley_mode, .o_offset, .o_panel_offer);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench for the remote input function control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import remote_ctl_pkg::*;
   // A short qualification time keeps the run brief; the design defaults to the full 20 ms count.
   localparam int     QUAL = 100;
   localparam logic [8:0] EPISODES = 9'h1d6;
   logic              i_clk = 1'b0;
   logic              i_nrst = 1'b0;
   logic              i_program_disable_pin_n = 1'b1;
   logic [3:0]        i_addr = 4'h0;
   logic [15:0]       i_wdata = 16'h0000;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic              i_sample_valid = 1'b0;
   logic [TEMP_W-1:0] i_temp = '0;
   logic              i_panel_select_total = 1'b0;
   logic              close1 = 1'b0;
   logic              close2 = 1'b0;
   wire logic         pin1_n;
   wire logic         pin2_n;
   logic [15:0]       o_rdata;
   logic [TEMP_W-1:0] o_display_temp;
   logic [TEMP_W-1:0] o_offset;
   logic [TEMP_W-1:0] o_peak;
   logic [TEMP_W-1:0] o_valley;
   logic [10:0]       o_panel_offer;
   logic              o_show_total;
   logic              o_total_clear;
   logic              o_total_enable;
   logic              o_total_hold;
   logic              o_alarm_clear;
   logic              o_peak_mode;
   logic              o_valley_mode;
   int                err_count = 0;
   int                n_compared = 0;
   int                events = 0;
   logic              busy = 1'b0;
   logic [15:0]       lo_st [9] = '{16'h0009, 16'h0009, 16'h0009, 16'h0009, 16'h000b,
                                    16'h0009, 16'h0019, 16'h0029, 16'h0009};
   logic [15:0]       raws [4] = '{16'h07ff, 16'h07aa, 16'h0055, 16'h0300};

   always #12.5 i_clk = ~i_clk;

   contact_model c1 (.i_close(close1), .o_pin_n(pin1_n));
   contact_model c2 (.i_close(close2), .o_pin_n(pin2_n));
   remote_input_function_control #(.MIN_CYCLES(QUAL)) dut (
      .i_clk, .i_nrst, .i_remote_input_one_n(pin1_n), .i_remote_input_two_n(pin2_n), .i_program_disable_pin_n,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sample_valid, .i_temp, .i_panel_select_total,
      .o_display_temp, .o_show_total, .o_total_clear, .o_total_enable, .o_total_hold, .o_alarm_clear,
      .o_peak_mode, .o_valley_mode, .o_offset, .o_peak, .o_valley, .o_panel_offer);

   // Counts each spell of activity on total clear, alarm clear, hold, peak or valley mode, so brief closures can be shown to do nothing.
   always @(posedge i_clk) begin
      busy <= |{o_total_clear, o_alarm_clear, o_peak_mode, o_valley_mode, o_total_hold};
      if (i_nrst && busy !== 1'b1 && {o_total_clear, o_alarm_clear, o_peak_mode, o_valley_mode, o_total_hold} !== 5'h00)
         events <= events + 1;
   end

   task report_and_stop;
      if (err_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name, input logic [15:0] m = 16'hffff);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      chk(name, exp & m, o_rdata & m);
   endtask

   task automatic sample(input logic [15:0] v);
      @(posedge i_clk);
      i_sample_valid <= 1'b1;
      i_temp         <= v;
      @(posedge i_clk);
      i_sample_valid <= 1'b0;
   endtask

   function automatic logic [15:0] pick(input bit disp);
      return disp ? o_display_temp : {15'h0000, o_show_total};
   endfunction

   // Edit permissions survive only where the matching display permission is set.
   function automatic logic [15:0] gate(input logic [15:0] r);
      gate = r & 16'h07ff;
      for (int k = 0; k < 4; k++) begin
         if (!r[2*k]) gate[2*k+1] = 1'b0;
      end
   endfunction

   task automatic wait_for(input bit disp, input logic [15:0] exp, input string name);
      for (int i = 0; i < 40 && pick(disp) !== exp; i++) begin
         @(posedge i_clk);
         #1;
      end
      chk(name, exp, pick(disp));
      if (pick(disp) !== exp) report_and_stop();
   endtask

   initial begin
      logic [15:0] e;
      logic [15:0] hi;
      int          ev0;
      repeat (12) @(posedge i_clk);
      i_nrst <= 1'b1;
      tick(2);
      rd(ADDR_CFG, CFG_RESET, "cfg");
      rd(ADDR_PANEL, PANEL_RESET, "panel");
      rd(ADDR_OFFSET, 16'h0000, "offset");
      rd(ADDR_PEAK, 16'h0000, "peak");
      rd(ADDR_VALLEY, 16'h0000, "valley");
      for (int a = 8; a < 16; a++) begin
         wr(4'(a), 16'hffff);
         rd(4'(a), 16'h0000, "unmapped");
      end
      wr(ADDR_PEAK, 16'h5a5a);
      wr(ADDR_VALLEY, 16'h5a5a);
      wr(ADDR_DISPLAY, 16'h5a5a);
      rd(ADDR_PEAK, 16'h0000, "peak read only");
      rd(ADDR_VALLEY, 16'h0000, "valley read only");
      rd(ADDR_DISPLAY, 16'h0000, "display read only");
      rd(ADDR_CFG, CFG_RESET, "cfg kept");
      wr(ADDR_CFG, 16'h1c00);
      rd(ADDR_CFG, 16'h1c00, "cfg");
      for (int p = 0; p < 2; p++) begin
         i_program_disable_pin_n <= 1'(p);
         tick(4);
         rd(ADDR_STATUS, (p == 0) ? 16'h0040 : 16'h0000, "status locked", 16'h0040);
         foreach (raws[k]) begin
            wr(ADDR_PANEL, raws[k]);
            rd(ADDR_PANEL, gate(raws[k]), "panel offer");
            chk("offer port", gate(raws[k]), {5'h00, o_panel_offer});
         end
      end
      wr(ADDR_PANEL, 16'h0100);
      i_panel_select_total <= 1'b1;
      wait_for(1'b0, 16'h0001, "show total");
      wr(ADDR_PANEL, 16'h0000);
      i_panel_select_total <= 1'b0;
      tick(8);
      chk("show total kept", 16'h0001, {15'h0000, o_show_total});
      wr(ADDR_PANEL, 16'h0100);
      wait_for(1'b0, 16'h0000, "show input");
      for (int lv = 0; lv < 4; lv++) begin
         wr(ADDR_CFG, 16'h1c00 | 16'(lv << 8));
         repeat (9) sample(16'h0100);
         wait_for(1'b1, 16'h0100, "display settled");
         repeat (2) sample(16'h0900);
         e = 16'h0100 + (16'h0800 >> lv);
         wait_for(1'b1, e, "display filtered");
         rd(ADDR_DISPLAY, e, "display reg");
      end
      wr(ADDR_OFFSET, 16'h0080);
      rd(ADDR_OFFSET, 16'h0080, "offset");
      chk("offset port", 16'h0080, o_offset);
      wait_for(1'b1, 16'h0180, "display minus offset");
      wr(ADDR_OFFSET, 16'h0000);
      for (int f = 0; f < 9; f++) begin
         ev0 = events;
         hi = (f == 2 || f == 3) ? 16'h0000 : 16'h0008;
         wr(ADDR_CFG, 16'h1c00 | 16'(f << 4) | 16'(f));
         close1 <= 1'b1;
         close2 <= 1'b1;
         tick(QUAL / 2);
         close1 <= 1'b0;
         close2 <= 1'b0;
         tick(20);
         rd(ADDR_STATUS, hi, "status brief", 16'h003b);
         close1 <= 1'b1;
         close2 <= 1'b1;
         tick(QUAL + 20);
         rd(ADDR_STATUS, lo_st[f], "status low", 16'h003b);
         close1 <= 1'b0;
         close2 <= 1'b0;
         tick(20);
         rd(ADDR_STATUS, hi, "status high", 16'h003b);
         chk("total enable", {15'h0000, hi[3]}, {15'h0000, o_total_enable});
         chk("remote actions", 16'(EPISODES[f]), 16'(events - ev0));
         if (f == 0) begin
            rd(ADDR_OFFSET, e, "offset capture");
            wr(ADDR_OFFSET, 16'h0000);
         end
         if (f == 5) begin
            rd(ADDR_PEAK, e, "peak cleared");
            chk("peak port", e, o_peak);
         end
      end
      rd(ADDR_OFFSET, 16'h0000, "offset kept");
      report_and_stop();
   end
endmodule
`default_nettype wire
